// [common/byte_stream_if.sv]
`timescale 1ns/1ps
interface byte_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

// [common/gbe_demo_pkg.sv]
// Contract
// - generator repeats one fixed 512-byte frame
// - checker asserts pass when payload matches pattern and frame length is right
// - checker asserts fail on any payload mismatch
// - loopback returns receive frames to transmit
// - all logic runs from one clock
// - registers reachable by MDIO or JTAG path
// - select input high picks MDIO, low JTAG
// - cores answer distinct five-bit MDIO addresses
// - JTAG windows at 0x800 and 0x810
// - low byte even address, high byte odd
// - control reg bits 12 reset, 9 restart
// - status reg bit 5 negotiation done
// - advert reg full 16-bit read/write
// - partner reg returns received ability word
// - expansion reg bit 1 page received
// - ident bytes at 0x820 and 0x821
// - bit 0 written at ident address 0x820 enables frame generator
// - debug input shortens link timer to 2us
// - activity output pulses on receive valid toggle
// - completion output on after negotiation done
// - pass and fail outputs follow checker
package gbe_demo_pkg;
  // ==========================================
  // timing
  localparam longint CLK_HZ = 25_000_000;
  localparam longint LT_SHORT_NS = 2_000;
  localparam longint LT_NORMAL_NS = 10_000_000;
  localparam int LT_SHORT_CYC = int'(LT_SHORT_NS * CLK_HZ / 1_000_000_000);
  localparam int LT_NORMAL_CYC = int'(LT_NORMAL_NS * CLK_HZ / 1_000_000_000);
  localparam int LT_W = 18;
  // ==========================================
  // frames
  localparam int FRAME_BYTES = 512;
  localparam int IFG_BYTES = 12;
  localparam int FCNT_W = 10;
  // ==========================================
  // management registers
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LP = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam int CTRL_RST_BIT = 12;
  localparam int CTRL_AN_BIT = 9;
  localparam int STAT_DONE_BIT = 5;
  localparam int EXP_PAGE_BIT = 1;
  localparam logic [15:0] ADV_RESET = 16'h0000;
  // ==========================================
  // jtag byte map
  localparam logic [11:0] JTAG_CORE0_BASE = 12'h800;
  localparam logic [11:0] JTAG_CORE1_BASE = 12'h810;
  localparam logic [11:0] JTAG_CORE_END = 12'h820;
  localparam logic [11:0] ID_LOW_ADDR = 12'h820;
  localparam logic [11:0] ID_HIGH_ADDR = 12'h821;
  // ident values are arbitrary
  localparam logic [7:0] ID_LOW_VAL = 8'h3c;
  localparam logic [7:0] ID_HIGH_VAL = 8'hc3;
  localparam int GEN_EN_BIT = 0;
  // ==========================================
  // mdio framing
  localparam logic [5:0] MDIO_PRE_BITS = 6'd32;
  localparam logic [5:0] MDIO_HDR_LAST = 6'd12;
  localparam logic [5:0] MDIO_DATA_LAST = 6'd15;
  localparam logic [1:0] OP_RD = 2'b10;
  localparam logic [1:0] OP_WR = 2'b01;
  typedef enum logic [1:0] {
    M_PRE = 2'b00,
    M_HDR = 2'b01,
    M_TA = 2'b11,
    M_DATA = 2'b10
  } mdio_st_t;
  function automatic logic [7:0] pat_byte(input logic [FCNT_W-1:0] i);
    return i[7:0];
  endfunction
endpackage

// [core/frame_gen.sv]
`timescale 1ns/1ps
module frame_gen import gbe_demo_pkg::*; #(
  parameter int FRAME_LEN = FRAME_BYTES,
  parameter int IFG = IFG_BYTES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // control
  input wire logic en,
  // frame stream
  byte_stream_if.src out_s
);
  if (FRAME_LEN < 2 || FRAME_LEN >= (1 << FCNT_W) || IFG < 1 || IFG > 255) begin : g_bad
    $error("frame_gen parameters out of range");
  end
  localparam logic [FCNT_W-1:0] LAST = FCNT_W'(FRAME_LEN - 1);
  typedef struct packed {
    logic [FCNT_W-1:0] cnt;
    logic [7:0] gap;
    logic inf;
    logic [7:0] d;
    logic v;
  } gen_t;
  gen_t q;
  gen_t n;
  // ==========================================
  // frame sequencer; a stall simply holds the byte
  always_comb begin
    n = q;
    if (!q.v || out_s.ready) begin
      n.v = 1'b0;
      if (q.inf) begin
        n.v = 1'b1;
        n.d = pat_byte(q.cnt);
        if (q.cnt == LAST) begin
          n.inf = 1'b0;
          n.cnt = '0;
          n.gap = 8'(IFG);
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end else if (q.gap != 8'h00) begin
        n.gap = q.gap - 8'h01;
      end else if (en) begin
        n.inf = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign out_s.data = q.d;
  assign out_s.valid = q.v;
  chk_gen_enable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(q.inf) |-> $past(en))
    else $error("frame started while disabled");
  chk_gen_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(q.inf) |-> $past(q.cnt) == LAST && q.v)
    else $error("frame length wrong");
endmodule

// [core/gbe_phy_demo_mgmt.sv]
`timescale 1ns/1ps
module gbe_phy_demo_mgmt import gbe_demo_pkg::*; #(
  parameter int FRAME_LEN = FRAME_BYTES,
  parameter int LINK_NORMAL_CYC = LT_NORMAL_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // access select and straps
  input wire logic enable_smi,
  input wire logic [4:0] core0_mgmt_port_addr,
  input wire logic [4:0] core1_mgmt_port_addr,
  input wire logic [1:0] link_timer_debug,
  // mdio serial management
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_out_en,
  // jtag register access, byte wide
  input wire logic jtag_req,
  input wire logic jtag_we,
  input wire logic [11:0] jtag_addr,
  input wire logic [7:0] jtag_wdata,
  output logic [7:0] jtag_rdata,
  output logic jtag_ack,
  // pcs core management, index 0 loopback, 1 driver
  output logic [1:0] core_soft_reset,
  output logic [1:0] negotiation_restart,
  output logic [1:0][15:0] local_ability_word,
  output logic [1:0][LT_W-1:0] link_timer_limit,
  input wire logic [1:0] negotiation_done,
  input wire logic [1:0][15:0] partner_ability_word,
  input wire logic [1:0] page_received_flag,
  // loopback channel gmii
  input wire logic [7:0] lb_rx_data,
  input wire logic lb_rx_dv,
  output logic lb_rx_ready,
  output logic [7:0] lb_tx_data,
  output logic lb_tx_en,
  input wire logic lb_tx_ready,
  // driver channel gmii
  output logic [7:0] drv_tx_data,
  output logic drv_tx_en,
  input wire logic drv_tx_ready,
  input wire logic [7:0] drv_rx_data,
  input wire logic drv_rx_dv,
  // indicators
  output logic [1:0] chan_activity,
  output logic [1:0] negotiation_done_indicator,
  output logic checker_pass_indicator,
  output logic checker_fail_indicator
);
  if (FRAME_LEN < 2 || FRAME_LEN >= (1 << FCNT_W)) begin : g_bad_len
    $error("frame length out of range");
  end
  if (LINK_NORMAL_CYC < 1 || LINK_NORMAL_CYC >= (1 << LT_W)) begin : g_bad_lt
    $error("link timer count out of range");
  end
  localparam logic [LT_W-1:0] LT_SHORT = LT_W'(LT_SHORT_CYC);
  localparam logic [LT_W-1:0] LT_LONG = LT_W'(LINK_NORMAL_CYC);
  localparam logic [FCNT_W-1:0] FLEN = FCNT_W'(FRAME_LEN);

  typedef struct packed {
    mdio_st_t mst;
    logic mdc_p;
    logic [5:0] bcnt;
    logic [12:0] hdr;
    logic [15:0] sh;
    logic rd;
    logic core;
    logic mo;
    logic moe;
    logic [1:0] rst;
    logic [1:0] an;
    logic [1:0][15:0] adv;
    logic gen_en;
    logic [7:0] jrd;
    logic jack;
    logic [FCNT_W-1:0] cnt;
    logic bad;
    logic pass;
    logic fail;
    logic [1:0] act;
    logic [1:0] rxp;
    logic [1:0] done;
    logic [1:0][LT_W-1:0] lt;
  } state_t;
  state_t st_q;
  state_t st_d;

  // ==========================================
  // datapath submodules
  byte_stream_if #(.W(8)) lb_in ();
  byte_stream_if #(.W(8)) lb_out ();
  byte_stream_if #(.W(8)) gen_s ();
  assign lb_in.data = lb_rx_data;
  assign lb_in.valid = lb_rx_dv;
  assign lb_out.ready = lb_tx_ready;
  assign gen_s.ready = drv_tx_ready;
  pair_buffer #(.W(8)) u_lb (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_s(lb_in),
    .out_s(lb_out)
  );
  frame_gen #(.FRAME_LEN(FRAME_LEN), .IFG(IFG_BYTES)) u_gen (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .en(st_q.gen_en),
    .out_s(gen_s)
  );

  // ==========================================
  // register read view, shared by both paths
  function automatic logic [15:0] rd_reg(input logic c, input logic [4:0] r);
    logic [15:0] v;
    v = '0;
    // unused addresses and bits are zero
    case (r)
      REG_CTRL: begin
        v[CTRL_RST_BIT] = st_q.rst[c];
        v[CTRL_AN_BIT] = st_q.an[c];
      end
      REG_STAT: v[STAT_DONE_BIT] = negotiation_done[c];
      REG_ADV: v = st_q.adv[c];
      REG_LP: v = partner_ability_word[c];
      REG_EXP: v[EXP_PAGE_BIT] = page_received_flag[c];
      default: v = '0;
    endcase
    return v;
  endfunction

  // ==========================================
  // next state
  always_comb begin
    logic rise;
    logic wv;
    logic wc;
    logic [4:0] wr;
    logic [15:0] wd;
    logic [15:0] wm;
    logic [15:0] nv;
    logic [12:0] h;
    logic [15:0] rv;
    logic ok;
    rise = mdc & ~st_q.mdc_p;
    wv = 1'b0;
    wc = 1'b0;
    wr = '0;
    wd = '0;
    wm = '0;
    nv = '0;
    h = {st_q.hdr[11:0], mdio_in};
    rv = '0;
    ok = 1'b0;
    st_d = st_q;
    st_d.mdc_p = mdc;
    st_d.jack = 1'b0;
    // mdc is sampled, so it must stay well below clk_sys
    // mdio engine held idle when not selected
    if (!enable_smi) begin
      st_d.mst = M_PRE;
      st_d.bcnt = '0;
      st_d.moe = 1'b0;
    end else if (rise) begin
      case (st_q.mst)
        M_PRE: begin
          if (mdio_in) begin
            if (st_q.bcnt != MDIO_PRE_BITS) begin
              st_d.bcnt = st_q.bcnt + 6'd1;
            end
          end else if (st_q.bcnt == MDIO_PRE_BITS) begin
            st_d.mst = M_HDR;
            st_d.bcnt = '0;
          end else begin
            st_d.bcnt = '0;
          end
        end
        M_HDR: begin
          st_d.hdr = h;
          st_d.bcnt = st_q.bcnt + 6'd1;
          if (st_q.bcnt == MDIO_HDR_LAST) begin
            st_d.bcnt = '0;
            st_d.mst = M_PRE;
            if (h[12] && (h[11:10] == OP_RD || h[11:10] == OP_WR) &&
                (h[9:5] == core0_mgmt_port_addr || h[9:5] == core1_mgmt_port_addr)) begin
              st_d.mst = M_TA;
              st_d.rd = (h[11:10] == OP_RD);
              st_d.core = (h[9:5] != core0_mgmt_port_addr);
            end
          end
        end
        M_TA: begin
          st_d.bcnt = st_q.bcnt + 6'd1;
          if (st_q.bcnt == 6'd0) begin
            st_d.mo = 1'b0;
            st_d.moe = st_q.rd;
          end else begin
            st_d.mst = M_DATA;
            st_d.bcnt = '0;
            rv = rd_reg(st_q.core, st_q.hdr[4:0]);
            st_d.mo = rv[15];
            st_d.sh = {rv[14:0], 1'b0};
          end
        end
        M_DATA: begin
          if (!st_q.rd) begin
            st_d.sh = {st_q.sh[14:0], mdio_in};
          end
          if (st_q.bcnt == MDIO_DATA_LAST) begin
            st_d.mst = M_PRE;
            st_d.bcnt = '0;
            st_d.moe = 1'b0;
            if (!st_q.rd) begin
              wv = 1'b1;
              wc = st_q.core;
              wr = st_q.hdr[4:0];
              wd = {st_q.sh[14:0], mdio_in};
              wm = 16'hffff;
            end
          end else begin
            st_d.bcnt = st_q.bcnt + 6'd1;
            if (st_q.rd) begin
              st_d.mo = st_q.sh[15];
              st_d.sh = {st_q.sh[14:0], 1'b0};
            end
          end
        end
        default: begin
          st_d.mst = M_PRE;
          st_d.moe = 1'b0;
        end
      endcase
    end

    // jtag path only when mdio deselected
    if (jtag_req && !enable_smi) begin
      st_d.jack = 1'b1;
      st_d.jrd = '0;
      if (jtag_addr >= JTAG_CORE0_BASE && jtag_addr < JTAG_CORE_END) begin
        wc = (jtag_addr >= JTAG_CORE1_BASE);
        wr = {2'b00, jtag_addr[3:1]};
        rv = rd_reg(wc, wr);
        // even low byte, odd high byte
        st_d.jrd = jtag_addr[0] ? rv[15:8] : rv[7:0];
        if (jtag_we) begin
          wv = 1'b1;
          wd = {jtag_wdata, jtag_wdata};
          wm = jtag_addr[0] ? 16'hff00 : 16'h00ff;
        end
      end else if (jtag_addr == ID_LOW_ADDR) begin
        // shared address, read ident, write enable
        st_d.jrd = ID_LOW_VAL;
        if (jtag_we) begin
          st_d.gen_en = jtag_wdata[GEN_EN_BIT];
        end
      end else if (jtag_addr == ID_HIGH_ADDR) begin
        st_d.jrd = ID_HIGH_VAL;
      end
    end

    if (wv) begin
      nv = (rd_reg(wc, wr) & ~wm) | (wd & wm);
      case (wr)
        REG_CTRL: begin
          st_d.rst[wc] = nv[CTRL_RST_BIT];
          st_d.an[wc] = nv[CTRL_AN_BIT];
        end
        REG_ADV: st_d.adv[wc] = nv;
        default: st_d.rst = st_d.rst;
      endcase
    end

    // ==========================================
    // checker on the driver channel
    if (drv_rx_dv) begin
      if (drv_rx_data != pat_byte(st_q.cnt)) begin
        st_d.bad = 1'b1;
        st_d.fail = 1'b1;
        st_d.pass = 1'b0;
      end
      if (st_q.cnt != '1) begin
        st_d.cnt = st_q.cnt + 1'b1;
      end
    end else if (st_q.rxp[1]) begin
      ok = !st_q.bad && st_q.cnt == FLEN;
      st_d.pass = ok;
      st_d.fail = !ok;
      st_d.cnt = '0;
      st_d.bad = 1'b0;
    end

    // ==========================================
    // indicators and timer select
    for (int i = 0; i < 2; i++) begin
      st_d.act[i] = (i == 0 ? lb_rx_dv : drv_rx_dv) != st_q.rxp[i];
      st_d.rxp[i] = (i == 0) ? lb_rx_dv : drv_rx_dv;
      st_d.done[i] = negotiation_done[i];
      st_d.lt[i] = link_timer_debug[i] ? LT_SHORT : LT_LONG;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.adv <= {2{ADV_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================
  // outputs
  assign mdio_out = st_q.mo;
  assign mdio_out_en = st_q.moe;
  assign jtag_rdata = st_q.jrd;
  assign jtag_ack = st_q.jack;
  assign core_soft_reset = st_q.rst;
  assign negotiation_restart = st_q.an;
  assign local_ability_word = st_q.adv;
  assign link_timer_limit = st_q.lt;
  assign lb_rx_ready = lb_in.ready;
  assign lb_tx_data = lb_out.data;
  assign lb_tx_en = lb_out.valid;
  assign drv_tx_data = gen_s.data;
  assign drv_tx_en = gen_s.valid;
  assign chan_activity = st_q.act;
  assign negotiation_done_indicator = st_q.done;
  assign checker_pass_indicator = st_q.pass;
  assign checker_fail_indicator = st_q.fail;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  chk_pass_good: assert property (
    $fell(drv_rx_dv) && !st_q.bad && st_q.cnt == FLEN |=> checker_pass_indicator && !checker_fail_indicator)
    else $error("good frame did not pass");
  chk_fail_bad: assert property (
    drv_rx_dv && drv_rx_data != pat_byte(st_q.cnt) |=> checker_fail_indicator && !checker_pass_indicator)
    else $error("mismatch did not fail");
  chk_status_read: assert property (
    jtag_req && !jtag_we && !enable_smi && jtag_addr == 12'h802
    |=> jtag_ack && jtag_rdata == {2'b00, $past(negotiation_done[0]), 5'b00000})
    else $error("status byte wrong");
  chk_ident_read: assert property (
    jtag_req && !jtag_we && !enable_smi && jtag_addr == ID_HIGH_ADDR |=> jtag_rdata == ID_HIGH_VAL)
    else $error("ident byte wrong");
  chk_shared_addr: assert property (
    jtag_req && jtag_we && !enable_smi && jtag_addr == ID_LOW_ADDR
    |=> jtag_rdata == ID_LOW_VAL && st_q.gen_en == $past(jtag_wdata[GEN_EN_BIT]))
    else $error("shared address misbehaves");
  chk_jtag_gated: assert property (
    enable_smi |=> !jtag_ack)
    else $error("jtag answered while mdio selected");
  chk_mdio_gated: assert property (
    !enable_smi |=> !mdio_out_en)
    else $error("mdio driven while jtag selected");
  chk_timer_sel: assert property (
    link_timer_debug[1] |=> link_timer_limit[1] == LT_SHORT)
    else $error("short timer not selected");
  chk_act_pulse: assert property (
    lb_rx_dv != $past(lb_rx_dv) |=> chan_activity[0])
    else $error("activity pulse missing");
  chk_done_ind: assert property (
    negotiation_done[1] ##1 negotiation_done[1] |-> negotiation_done_indicator[1])
    else $error("completion indicator off");
  cover property ($rose(checker_pass_indicator));
  cover property ($rose(checker_fail_indicator));
  cover property ($rose(mdio_out_en));
  cover property (jtag_ack && st_q.gen_en);
endmodule

// [core/pair_buffer.sv]
`timescale 1ns/1ps
module pair_buffer import gbe_demo_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // streams
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  if (W < 1) begin : g_bad
    $error("pair_buffer width must be positive");
  end
  typedef struct packed {
    logic [W-1:0] o_d;
    logic [W-1:0] s_d;
    logic o_v;
    logic s_v;
    logic rdy;
  } buf_t;
  buf_t q;
  buf_t n;
  logic push;
  logic pop;
  assign push = in_s.valid & q.rdy;
  assign pop = q.o_v & out_s.ready;
  // ==========================================
  // two slots: output word plus skid word
  always_comb begin
    n = q;
    if (pop || !q.o_v) begin
      if (q.s_v) begin
        n.o_d = q.s_d;
        n.o_v = 1'b1;
        n.s_v = push;
        n.s_d = in_s.data;
      end else begin
        n.o_v = push;
        n.o_d = in_s.data;
      end
    end else if (push) begin
      n.s_d = in_s.data;
      n.s_v = 1'b1;
    end
    n.rdy = ~n.s_v;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end
  assign in_s.ready = q.rdy;
  assign out_s.data = q.o_d;
  assign out_s.valid = q.o_v;
  chk_lb_forward: assert property (@(posedge clk_sys) disable iff (sys_rst)
    push && !q.o_v |=> q.o_v && q.o_d == $past(in_s.data))
    else $error("loopback word not forwarded");
  cover property (@(posedge clk_sys) disable iff (sys_rst) !q.rdy);
endmodule

// [test/mgmt_host.sv]
`timescale 1ns/1ps
// ==========================================
// byte-port management host
module mgmt_host (
  // clock
  input wire logic clk_sys,
  // register access port
  output logic jtag_req,
  output logic jtag_we,
  output logic [11:0] jtag_addr,
  output logic [7:0] jtag_wdata,
  input wire logic jtag_ack,
  // mdio station
  output logic mdc,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_out_en
);
  initial begin
    mdc = 1'b0;
    mdio_in = 1'b1;
    jtag_req = 1'b0;
    jtag_we = 1'b0;
    jtag_addr = 12'h000;
    jtag_wdata = 8'h00;
  end
  task automatic access(input logic we, input logic [11:0] a, input logic [7:0] d, output logic got);
    got = 1'b0;
    @(posedge clk_sys);
    jtag_req <= 1'b1;
    jtag_we <= we;
    jtag_addr <= a;
    jtag_wdata <= d;
    @(posedge clk_sys);
    jtag_req <= 1'b0;
    // released lines carry junk so a stale value never passes
    jtag_addr <= ~a;
    jtag_wdata <= ~d;
    for (int i = 0; i < 3 && !got; i++) begin
      @(posedge clk_sys);
      got = jtag_ack;
    end
  endtask
  task automatic mdio_frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
                            output logic [15:0] got, output logic [15:0] oe);
    logic [63:0] f;
    // a released line reads as its pull-up, so reads pass ones in the turnaround
    f = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, rd ? 2'b11 : 2'b10, wd};
    got = 16'h0000;
    oe = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_sys);
      mdc <= 1'b0;
      mdio_in <= f[i];
      repeat (4) @(posedge clk_sys);
      // sample just before the rise, long after the device moved its bit
      if (i < 16) begin
        got = {got[14:0], mdio_out};
        oe = {oe[14:0], mdio_out_en};
      end
      mdc <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import gbe_demo_pkg::*;
  localparam int FL = 16;
  logic clk_sys = 1'b0, sys_rst = 1'b1, enable_smi = 1'b0, got, lb_on = 1'b0, stall = 1'b0;
  logic jtag_req, jtag_we, jtag_ack, lb_rx_dv, lb_rx_ready, lb_tx_en, lb_tx_ready, drv_tx_en, drv_rx_dv;
  logic checker_pass_indicator, checker_fail_indicator;
  logic [11:0] jtag_addr;
  logic [7:0] jtag_wdata, jtag_rdata, lb_rx_data, lb_tx_data, drv_tx_data, drv_rx_data, gidx = 8'h00;
  logic [7:0] corrupt = 8'h00;
  logic mdc, mdio_in, mdio_out, mdio_out_en;
  logic [15:0] mw, me;
  logic [1:0] dvh = 2'b00;
  logic [1:0] core_soft_reset, negotiation_restart, chan_activity, negotiation_done_indicator;
  logic [1:0] link_timer_debug = 2'b01, negotiation_done = 2'b01, page_received_flag = 2'b10;
  logic [1:0][15:0] local_ability_word;
  logic [1:0][15:0] partner_ability_word = {16'hbeef, 16'h1234};
  logic [1:0][LT_W-1:0] link_timer_limit;
  logic [8:0] jq[$];
  logic [8:0] jx;
  logic [7:0] lq[$];
  integer seed = 32'hb67a;
  int bad_count = 0, total_checks = 0;
  gbe_phy_demo_mgmt #(.FRAME_LEN(FL), .LINK_NORMAL_CYC(200)) gbe_phy_demo_mgmt_inst (
    .clk_sys, .sys_rst, .enable_smi, .core0_mgmt_port_addr(5'h01), .core1_mgmt_port_addr(5'h02),
    .link_timer_debug, .mdc, .mdio_in, .mdio_out, .mdio_out_en,
    .jtag_req, .jtag_we, .jtag_addr, .jtag_wdata, .jtag_rdata, .jtag_ack,
    .core_soft_reset, .negotiation_restart, .local_ability_word, .link_timer_limit,
    .negotiation_done, .partner_ability_word, .page_received_flag,
    .lb_rx_data, .lb_rx_dv, .lb_rx_ready, .lb_tx_data, .lb_tx_en, .lb_tx_ready,
    .drv_tx_data, .drv_tx_en, .drv_tx_ready(1'b1), .drv_rx_data, .drv_rx_dv,
    .chan_activity, .negotiation_done_indicator, .checker_pass_indicator, .checker_fail_indicator
  );
  mgmt_host mgmt_host_inst (.clk_sys, .jtag_req, .jtag_we, .jtag_addr, .jtag_wdata, .jtag_ack,
    .mdc, .mdio_in, .mdio_out, .mdio_out_en);
  initial forever #20 clk_sys = ~clk_sys;
  // ==========================================
  // compare and closing
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [17:0] e, input logic [17:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // expected read byte is queued before the request goes out
  task automatic acc(input logic we, input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
    jq.push_back({~we, e});
    mgmt_host_inst.access(we, a, d, got);
    chk_byte("ack", 8'h01, {7'h00, got});
  endtask
  // ==========================================
  // stream drivers, random with held requests
  always @(posedge clk_sys) begin
    if (lb_rx_dv && lb_rx_ready) lq.push_back(lb_rx_data);
    if (!lb_rx_dv || lb_rx_ready) begin
      lb_rx_dv <= lb_on & 1'($random(seed));
      lb_rx_data <= 8'($random(seed));
    end
    lb_tx_ready <= !stall & 1'($random(seed));
    drv_rx_dv <= drv_tx_en;
    drv_rx_data <= drv_tx_data ^ corrupt;
  end
  // ==========================================
  // result watcher
  always @(posedge clk_sys) begin
    if (jtag_ack) begin
      jx = jq.pop_front();
      if (jx[8]) chk_byte("rdata", jx[7:0], jtag_rdata);
    end
    if (lb_tx_en && lb_tx_ready) chk_byte("loop", lq.pop_front(), lb_tx_data);
    chk_byte("act1", {7'h00, ^dvh}, {7'h00, chan_activity[1]});
    dvh <= {dvh[0], drv_rx_dv};
    if (drv_tx_en) begin
      chk_byte("gen", gidx, drv_tx_data);
      gidx <= (gidx == 8'(FL - 1)) ? 8'h00 : gidx + 8'h01;
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    finish_test;
  end
  // ==========================================
  // main sequence
  initial begin
    lb_rx_dv = 1'b0;
    lb_rx_data = 8'h00;
    lb_tx_ready = 1'b0;
    drv_rx_dv = 1'b0;
    drv_rx_data = 8'h00;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_word("timer0", 18'(LT_SHORT_CYC), link_timer_limit[0]);
    chk_word("timer1", 18'd200, link_timer_limit[1]);
    acc(1'b0, ID_LOW_ADDR, 8'h00, ID_LOW_VAL);
    acc(1'b0, ID_HIGH_ADDR, 8'h00, ID_HIGH_VAL);
    acc(1'b0, 12'h802, 8'h00, 8'h20);
    acc(1'b0, 12'h812, 8'h00, 8'h00);
    acc(1'b0, 12'h80a, 8'h00, 8'h34);
    acc(1'b0, 12'h81b, 8'h00, 8'hbe);
    acc(1'b0, 12'h81c, 8'h00, 8'h02);
    acc(1'b0, 12'h80c, 8'h00, 8'h00);
    acc(1'b1, 12'h808, 8'ha5, 8'h00);
    acc(1'b1, 12'h809, 8'h5a, 8'h00);
    acc(1'b0, 12'h809, 8'h00, 8'h5a);
    chk_word("advert", 18'h05aa5, {2'b00, local_ability_word[0]});
    acc(1'b1, 12'h801, 8'hff, 8'h00);
    acc(1'b0, 12'h801, 8'h00, 8'h12);
    acc(1'b1, 12'h810, 8'hff, 8'h00);
    acc(1'b0, 12'h810, 8'h00, 8'h00);
    chk_word("soft_reset", 18'h1, {16'h0, core_soft_reset});
    chk_word("restart", 18'h1, {16'h0, negotiation_restart});
    acc(1'b1, 12'h803, 8'hff, 8'h00);
    acc(1'b0, 12'h803, 8'h00, 8'h00);
    acc(1'b1, 12'h804, 8'hff, 8'h00);
    acc(1'b0, 12'h805, 8'h00, 8'h00);
    enable_smi <= 1'b1;
    mgmt_host_inst.access(1'b0, ID_LOW_ADDR, 8'h00, got);
    chk_byte("ignored", 8'h00, {7'h00, got});
    mgmt_host_inst.mdio_frame(1'b0, 5'h02, 5'h04, 16'hc35a, mw, me);
    chk_word("mdio_wr_oe", 18'h0, {2'b00, me});
    mgmt_host_inst.mdio_frame(1'b1, 5'h01, 5'h04, 16'hffff, mw, me);
    chk_word("mdio_rd0", 18'h05aa5, {2'b00, mw});
    chk_word("mdio_rd_oe", 18'h0ffff, {2'b00, me});
    mgmt_host_inst.mdio_frame(1'b1, 5'h02, 5'h04, 16'hffff, mw, me);
    chk_word("mdio_rd1", 18'h0c35a, {2'b00, mw});
    chk_word("advert1", 18'h0c35a, {2'b00, local_ability_word[1]});
    enable_smi <= 1'b0;
    chk_word("done_ind", 18'h1, {16'h0, negotiation_done_indicator});
    negotiation_done <= 2'b11;
    link_timer_debug <= 2'b10;
    repeat (3) @(posedge clk_sys);
    chk_word("done_ind2", 18'h3, {16'h0, negotiation_done_indicator});
    chk_word("timer1s", 18'(LT_SHORT_CYC), link_timer_limit[1]);
    chk_word("timer0l", 18'd200, link_timer_limit[0]);
    lb_on <= 1'b1;
    repeat (100) @(posedge clk_sys);
    stall <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_byte("full", 8'h00, {7'h00, lb_rx_ready});
    stall <= 1'b0;
    repeat (150) @(posedge clk_sys);
    lb_on <= 1'b0;
    repeat (40) @(posedge clk_sys);
    chk_word("left", 18'h0, 18'(lq.size()));
    acc(1'b1, ID_LOW_ADDR, 8'h01, 8'h00);
    repeat (100) @(posedge clk_sys);
    chk_word("pass", 18'h1, {16'h0, checker_fail_indicator, checker_pass_indicator});
    corrupt <= 8'h40;
    repeat (40) @(posedge clk_sys);
    chk_word("fail", 18'h2, {16'h0, checker_fail_indicator, checker_pass_indicator});
    corrupt <= 8'h00;
    repeat (70) @(posedge clk_sys);
    chk_word("repass", 18'h1, {16'h0, checker_fail_indicator, checker_pass_indicator});
    acc(1'b1, ID_LOW_ADDR, 8'h00, 8'h00);
    repeat (40) @(posedge clk_sys);
    chk_byte("gen_off", 8'h00, {7'h00, drv_tx_en});
    finish_test;
  end
endmodule
